// ### src/dcs_pkg.sv
// Shared types and constants for the command sequencing link.
// Assumes both link ends and the link interface compile after it.
package dcs_pkg;

	// ----------------------------------------
	// Commands on the link
	// ----------------------------------------
	typedef enum logic [3:0] {
		DCS_NOP = 4'h0,
		DCS_ACT = 4'h1,
		DCS_RD = 4'h2,
		DCS_WR = 4'h3,
		DCS_PRE = 4'h4,
		DCS_MODE = 4'h5,
		DCS_REF = 4'h6,
		DCS_SRE = 4'h7,
		DCS_SRX = 4'h8
	} dcs_cmd_t;

	// ----------------------------------------
	// Widths and latencies (link clocks)
	// ----------------------------------------
	localparam int DQ_W = 32;
	localparam int ADDR_W = 13;
	localparam int MEM_WORDS = 64;
	localparam logic [7:0] ADDITIVE_LATENCY = 8'h02;
	localparam logic [7:0] COLUMN_LATENCY = 8'h03;
	localparam logic [7:0] READ_LATENCY = ADDITIVE_LATENCY + COLUMN_LATENCY;
	localparam logic [7:0] WRITE_LATENCY = READ_LATENCY - 8'h01;

	// ----------------------------------------
	// Mode register fields
	// ----------------------------------------
	localparam logic [1:0] MODE_BANK = 2'h0;
	localparam logic [1:0] EXT1_BANK = 2'h1;
	localparam int MR_BL_LSB = 0;
	localparam logic [2:0] MR_BL8 = 3'h3;
	localparam int MR_BT_BIT = 3;
	localparam int EMR_RTT_HI = 6;
	localparam int EMR_RTT_LO = 2;
	localparam int EMR_CAL_LSB = 7;
	localparam logic [2:0] CAL_EXIT = 3'h0;
	localparam logic [2:0] CAL_DRIVE1 = 3'h1;
	localparam logic [2:0] CAL_DRIVE0 = 3'h2;
	localparam logic [2:0] CAL_ADJUST = 3'h4;
	localparam int AUTO_PRE_BIT = 10;

	// ----------------------------------------
	// Spacing, in link clocks
	// ----------------------------------------
	localparam logic [7:0] OIT_CK = 8'h02;
	localparam logic [7:0] WTR_CK = 8'h02;
	localparam logic [7:0] WR_CK = 8'h03;
	localparam logic [7:0] AOFD_CK = 8'h03;
	localparam logic [7:0] MOD_MAX_CK = 8'h0C;
	localparam logic [7:0] XSNR_CK = 8'h14;
	localparam logic [7:0] XSRD_CK = 8'hC8;
	localparam logic [7:0] RTW_BL4_CK = 8'h04;
	localparam logic [7:0] RTW_BL8_CK = 8'h06;
	localparam logic [7:0] TRUNC_GAP_CK = 8'h02;
	localparam logic [7:0] HALF_BL4 = 8'h02;
	localparam logic [7:0] HALF_BL8 = 8'h04;
	localparam logic [7:0] SINCE_MAX = 8'hFF;

endpackage

// ### src/dcs_link_if.sv
// Link between the controller end and the device end.
// Assumes dcs_pkg first; the bench instantiates it and joins both ends.
`timescale 1ns/10ps
`default_nettype none
interface dcs_link_if;
	logic ck;
	dcs_pkg::dcs_cmd_t cmd;
	logic [1:0] bank;
	logic [12:0] addr;
	logic term;
	logic [31:0] dq_ctl_o;
	logic dq_ctl_oe;
	logic [31:0] dq_dev_o;
	logic dq_dev_oe;
	logic [31:0] dq;

	// Resolved data lanes
	assign dq = dq_dev_oe ? dq_dev_o : (dq_ctl_oe ? dq_ctl_o : 32'h0000_0000);

	modport ctl (
		output ck, cmd, bank, addr, term, dq_ctl_o, dq_ctl_oe,
		input dq
	);
	modport dev (
		input ck, cmd, bank, addr, term, dq,
		output dq_dev_o, dq_dev_oe
	);
endinterface
`default_nettype wire

// ### src/dcs_device_end.sv
// Memory device end: decodes link commands on the link clock.
// Assumes the controller keeps all spacing; status crosses to clk_sys.
`timescale 1ns/10ps
`default_nettype none
module dcs_device_end (
	// Link
	dcs_link_if.dev link,
	// System clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Status in clk_sys domain
	output logic [3:0] bank_open,
	output logic self_refresh,
	output logic cal_drive_active,
	output logic termination_active,
	output logic [1:0] rtt_nominal,
	output logic [15:0] adjust_code
);
	localparam int RL = int'(dcs_pkg::READ_LATENCY);
	localparam int WL = int'(dcs_pkg::WRITE_LATENCY);

	typedef struct packed {
		logic [3:0] open;
		logic sref;
		logic bl8;
		logic inter;
		logic [1:0] rtt;
		logic tgl;
		logic [2:0] cal;
		logic [7:0] oit;
		logic drive;
		logic drv_one;
		logic term_on;
		logic [RL-1:0] rv;
		logic [RL-1:0][6:0] ri;
		logic [WL-1:0] wv;
		logic [WL-1:0][6:0] wi;
		logic ract;
		logic [2:0] rk;
		logic [6:0] rcur;
		logic wact;
		logic [2:0] wk;
		logic [6:0] wcur;
		logic [15:0] adj;
		logic [31:0] dq_o;
		logic dq_oe;
	} dcs_dev_link_t;

	typedef struct packed {
		logic [3:0] open_a;
		logic [3:0] open_b;
		logic sref_a;
		logic sref_b;
		logic drv_a;
		logic drv_b;
		logic term_a;
		logic term_b;
		logic tgl_a;
		logic tgl_b;
		logic tgl_c;
		logic [1:0] rtt;
		logic [15:0] adj;
	} dcs_dev_sys_t;

	dcs_dev_link_t s, n;
	dcs_dev_sys_t y, yn;
	logic [31:0] mem [0:dcs_pkg::MEM_WORDS-1];
	logic we;
	logic [5:0] wa;
	logic [31:0] wd;
	logic [2:0] nw;
	logic wgo;
	logic [6:0] winfo;
	logic [1:0] wkk;

	// ----------------------------------------
	// Word address of beat pair k in a burst
	// ----------------------------------------
	function automatic logic [5:0] dcs_word(input logic [6:0] info, input logic [1:0] k,
		input logic bl8, input logic inter);
		logic [1:0] off;
		off = inter ? (info[1:0] ^ k) : (info[1:0] + k);
		if (bl8)
			return {info[5:2], off};
		return {info[5:1], off[0]};
	endfunction

	// ----------------------------------------
	// Link domain
	// ----------------------------------------
	always_comb
	begin
		n = s;
		we = 1'b0;
		wa = 6'h00;
		wd = link.dq;
		wgo = 1'b0;
		winfo = s.wcur;
		wkk = s.wk[1:0];
		nw = s.bl8 ? 3'h4 : 3'h2;
		n.rv = {s.rv[RL-2:0], 1'b0};
		n.ri = {s.ri[RL-2:0], 7'h00};
		n.wv = {s.wv[WL-2:0], 1'b0};
		n.wi = {s.wi[WL-2:0], 7'h00};
		n.dq_oe = 1'b0;
		n.term_on = link.term && (s.rtt != 2'h0);
		// Read burst: end, then a new start overrides (seamless or cut short)
		if (s.ract && s.rk == nw)
		begin
			n.ract = 1'b0;
			if (s.rcur[6])
				n.open[s.rcur[5:4]] = 1'b0;
		end
		else if (s.ract)
		begin
			n.rk = s.rk + 3'h1;
			n.dq_o = mem[dcs_word(s.rcur, s.rk[1:0], s.bl8, s.inter)];
			n.dq_oe = 1'b1;
		end
		if (s.rv[RL-1])
		begin
			n.ract = 1'b1;
			n.rcur = s.ri[RL-1];
			n.rk = 3'h1;
			n.dq_o = mem[dcs_word(s.ri[RL-1], 2'h0, s.bl8, s.inter)];
			n.dq_oe = 1'b1;
		end
		// Write burst, same structure
		if (s.wact && s.wk == nw)
		begin
			n.wact = 1'b0;
			if (s.wcur[6])
				n.open[s.wcur[5:4]] = 1'b0;
		end
		else if (s.wact)
		begin
			n.wk = s.wk + 3'h1;
			wgo = 1'b1;
		end
		if (s.wv[WL-1])
		begin
			n.wact = 1'b1;
			n.wcur = s.wi[WL-1];
			n.wk = 3'h1;
			wgo = 1'b1;
			winfo = s.wi[WL-1];
			wkk = 2'h0;
		end
		if (wgo && s.cal == dcs_pkg::CAL_ADJUST)
		begin
			n.adj[{wkk, 2'h0} +: 4] = link.dq[3:0];
			n.tgl = ~n.tgl;
		end
		else if (wgo)
		begin
			we = 1'b1;
			wa = dcs_word(winfo, wkk, s.bl8, s.inter);
		end
		// Impedance drive mode delay
		if (s.oit != 8'h00)
			n.oit = s.oit - 8'h01;
		if (s.oit == 8'h01)
			n.drive = (s.cal == dcs_pkg::CAL_DRIVE1) || (s.cal == dcs_pkg::CAL_DRIVE0);
		if (s.drive)
		begin
			n.dq_o = s.drv_one ? 32'hFFFF_FFFF : 32'h0000_0000;
			n.dq_oe = 1'b1;
		end
		// Command decode
		if (s.sref)
		begin
			if (link.cmd == dcs_pkg::DCS_SRX)
				n.sref = 1'b0;
		end
		else
		begin
			case (link.cmd)
			dcs_pkg::DCS_ACT: n.open[link.bank] = 1'b1;
			dcs_pkg::DCS_PRE:
			begin
				if (link.addr[dcs_pkg::AUTO_PRE_BIT])
					n.open = 4'h0;
				else
					n.open[link.bank] = 1'b0;
			end
			dcs_pkg::DCS_RD:
			begin
				n.rv[0] = 1'b1;
				n.ri[0] = {link.addr[dcs_pkg::AUTO_PRE_BIT], link.bank, link.addr[3:0]};
			end
			dcs_pkg::DCS_WR:
			begin
				n.wv[0] = 1'b1;
				n.wi[0] = {link.addr[dcs_pkg::AUTO_PRE_BIT], link.bank, link.addr[3:0]};
			end
			dcs_pkg::DCS_MODE:
			begin
				if (link.bank == dcs_pkg::MODE_BANK)
				begin
					n.bl8 = link.addr[dcs_pkg::MR_BL_LSB +: 3] == dcs_pkg::MR_BL8;
					n.inter = link.addr[dcs_pkg::MR_BT_BIT];
				end
				else if (link.bank == dcs_pkg::EXT1_BANK)
				begin
					n.rtt = {link.addr[dcs_pkg::EMR_RTT_HI],
						link.addr[dcs_pkg::EMR_RTT_LO]};
					n.tgl = ~n.tgl;
					n.cal = link.addr[dcs_pkg::EMR_CAL_LSB +: 3];
					if (n.cal == dcs_pkg::CAL_DRIVE1 || n.cal == dcs_pkg::CAL_DRIVE0)
					begin
						n.oit = dcs_pkg::OIT_CK;
						n.drv_one = n.cal == dcs_pkg::CAL_DRIVE1;
					end
					else if (n.cal == dcs_pkg::CAL_EXIT && s.drive)
						n.oit = dcs_pkg::OIT_CK;
				end
			end
			dcs_pkg::DCS_SRE:
			begin
				if (s.open == 4'h0)
					n.sref = 1'b1;
			end
			default:
			begin
			end
			endcase
		end
	end

	always_ff @(posedge link.ck or posedge rst)
	begin
		if (rst)
			s <= '0;
		else
			s <= n;
	end

	always_ff @(posedge link.ck)
	begin
		if (we)
			mem[wa] <= wd;
	end

	assign link.dq_dev_o = s.dq_o;
	assign link.dq_dev_oe = s.dq_oe;

	// ----------------------------------------
	// System domain: level syncs and toggle capture
	// ----------------------------------------
	always_comb
	begin
		yn = y;
		yn.open_a = s.open;
		yn.open_b = y.open_a;
		yn.sref_a = s.sref;
		yn.sref_b = y.sref_a;
		yn.drv_a = s.drive;
		yn.drv_b = y.drv_a;
		yn.term_a = s.term_on;
		yn.term_b = y.term_a;
		yn.tgl_a = s.tgl;
		yn.tgl_b = y.tgl_a;
		yn.tgl_c = y.tgl_b;
		if (y.tgl_b != y.tgl_c)
		begin
			yn.rtt = s.rtt;
			yn.adj = s.adj;
		end
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			y <= '0;
		else
			y <= yn;
	end

	assign bank_open = y.open_b;
	assign self_refresh = y.sref_b;
	assign cal_drive_active = y.drv_b;
	assign termination_active = y.term_b;
	assign rtt_nominal = y.rtt;
	assign adjust_code = y.adj;
endmodule
`default_nettype wire

// ### src/dcs_controller_end.sv
// Controller end: makes the link clock by dividing clk_sys by two
// and issues user requests only when command spacing allows.
`timescale 1ns/10ps
`default_nettype none
module dcs_controller_end (
	// System clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Link
	dcs_link_if.ctl link,
	// Command requests
	input wire logic req_valid,
	input wire dcs_pkg::dcs_cmd_t req_cmd,
	input wire logic [1:0] req_bank,
	input wire logic [12:0] req_addr,
	output logic req_ready,
	// Termination wish
	input wire logic term_enable,
	// Write data
	input wire logic [31:0] wr_data,
	output logic wr_take,
	// Read data
	output logic [31:0] rd_data,
	output logic rd_valid,
	// Status
	output logic [3:0] bank_open,
	output logic self_refresh
);
	localparam int RL = int'(dcs_pkg::READ_LATENCY);
	localparam int WL = int'(dcs_pkg::WRITE_LATENCY);
	localparam int WS = WL + 3;
	localparam int RS = RL + 5;

	typedef struct packed {
		logic ck;
		dcs_pkg::dcs_cmd_t cmd;
		logic [1:0] bank;
		logic [12:0] addr;
		logic term;
		logic [31:0] dq_o;
		logic dq_oe;
		logic bl8;
		logic [3:0] open;
		logic sref;
		logic rd_ap;
		logic wr_ap;
		logic [7:0] since_rd;
		logic [7:0] since_wr;
		logic [7:0] since_ext;
		logic [7:0] since_srx;
		logic [7:0] since_toff;
		logic [WS-1:0] wsched;
		logic [RS-1:0] rcap;
		logic [31:0] sync_a;
		logic [31:0] sync_b;
		logic [31:0] rd_data;
		logic rd_valid;
	} dcs_ctl_t;

	dcs_ctl_t s, n;
	logic [7:0] half;
	logic [7:0] rtw;
	logic quiet;
	logic live;
	logic ext1;
	logic ok;
	logic hold;
	logic [3:0] words;

	// ----------------------------------------
	// Saturating cycle counter step
	// ----------------------------------------
	function automatic logic [7:0] dcs_inc(input logic [7:0] v);
		return (v == dcs_pkg::SINCE_MAX) ? v : v + 8'h01;
	endfunction

	// ----------------------------------------
	// Spacing checks
	// ----------------------------------------
	always_comb
	begin
		half = s.bl8 ? dcs_pkg::HALF_BL8 : dcs_pkg::HALF_BL4;
		rtw = s.bl8 ? dcs_pkg::RTW_BL8_CK : dcs_pkg::RTW_BL4_CK;
		words = s.bl8 ? 4'hF : 4'h3;
		quiet = (s.since_rd >= dcs_pkg::ADDITIVE_LATENCY + half)
			&& (s.since_wr >= dcs_pkg::WRITE_LATENCY + half + dcs_pkg::WR_CK);
		live = !s.sref && (s.since_srx >= dcs_pkg::XSNR_CK);
		ext1 = (req_cmd == dcs_pkg::DCS_MODE) && (req_bank == dcs_pkg::EXT1_BANK);
		ok = 1'b0;
		case (req_cmd)
		dcs_pkg::DCS_NOP: ok = 1'b1;
		dcs_pkg::DCS_ACT: ok = live && !s.open[req_bank];
		dcs_pkg::DCS_RD:
		begin
			ok = !s.sref && (s.since_srx >= dcs_pkg::XSRD_CK)
				&& s.open[req_bank]
				&& (s.since_wr >= dcs_pkg::COLUMN_LATENCY - 8'h01 + half
				+ dcs_pkg::WTR_CK)
				&& ((s.since_rd >= half)
				|| (s.bl8 && !s.rd_ap
				&& s.since_rd == dcs_pkg::TRUNC_GAP_CK));
		end
		dcs_pkg::DCS_WR:
		begin
			ok = live && s.open[req_bank]
				&& (s.since_rd >= rtw)
				&& ((s.since_wr >= half)
				|| (s.bl8 && !s.wr_ap
				&& s.since_wr == dcs_pkg::TRUNC_GAP_CK));
		end
		dcs_pkg::DCS_PRE: ok = live && quiet;
		dcs_pkg::DCS_MODE:
		begin
			ok = live && quiet && (s.open == 4'h0)
				&& (!ext1 || (!s.term
				&& s.since_toff >= dcs_pkg::AOFD_CK));
		end
		dcs_pkg::DCS_REF: ok = live && quiet && (s.open == 4'h0);
		dcs_pkg::DCS_SRE:
		begin
			ok = live && quiet && (s.open == 4'h0)
				&& !s.term && (s.since_toff >= dcs_pkg::AOFD_CK);
		end
		dcs_pkg::DCS_SRX: ok = s.sref;
		default: ok = 1'b0;
		endcase
		// Termination held low through extended mode update and self refresh
		hold = s.sref || (s.since_ext <= dcs_pkg::MOD_MAX_CK)
			|| (s.since_srx < dcs_pkg::XSRD_CK)
			|| (req_valid && (ext1 || req_cmd == dcs_pkg::DCS_SRE));
	end

	assign req_ready = s.ck && ok;
	assign wr_take = s.ck && s.wsched[0];

	// ----------------------------------------
	// Next state: commands change on the falling link edge
	// ----------------------------------------
	always_comb
	begin
		n = s;
		n.ck = ~s.ck;
		n.sync_a = link.dq;
		n.sync_b = s.sync_a;
		n.rd_valid = 1'b0;
		if (s.ck)
		begin
			n.cmd = dcs_pkg::DCS_NOP;
			n.dq_oe = 1'b0;
			n.since_rd = dcs_inc(s.since_rd);
			n.since_wr = dcs_inc(s.since_wr);
			n.since_ext = dcs_inc(s.since_ext);
			n.since_srx = dcs_inc(s.since_srx);
			n.since_toff = s.term ? 8'h00 : dcs_inc(s.since_toff);
			n.wsched = s.wsched >> 1;
			n.rcap = s.rcap >> 1;
			n.term = term_enable && !hold;
			if (s.wsched[0])
			begin
				n.dq_o = wr_data;
				n.dq_oe = 1'b1;
			end
			if (s.rcap[0])
			begin
				n.rd_data = s.sync_b;
				n.rd_valid = 1'b1;
			end
			if (req_valid && ok)
			begin
				n.cmd = req_cmd;
				n.bank = req_bank;
				n.addr = req_addr;
				case (req_cmd)
				dcs_pkg::DCS_ACT: n.open[req_bank] = 1'b1;
				dcs_pkg::DCS_PRE:
				begin
					if (req_addr[dcs_pkg::AUTO_PRE_BIT])
						n.open = 4'h0;
					else
						n.open[req_bank] = 1'b0;
				end
				dcs_pkg::DCS_RD:
				begin
					n.since_rd = 8'h01;
					n.rd_ap = req_addr[dcs_pkg::AUTO_PRE_BIT];
					if (n.rd_ap)
						n.open[req_bank] = 1'b0;
					n.rcap = (s.rcap >> 1) | (RS'(words) << (RL + 1));
				end
				dcs_pkg::DCS_WR:
				begin
					n.since_wr = 8'h01;
					n.wr_ap = req_addr[dcs_pkg::AUTO_PRE_BIT];
					if (n.wr_ap)
						n.open[req_bank] = 1'b0;
					n.wsched = (s.wsched >> 1) | (WS'(words) << (WL - 1));
				end
				dcs_pkg::DCS_MODE:
				begin
					if (req_bank == dcs_pkg::MODE_BANK)
						n.bl8 = req_addr[dcs_pkg::MR_BL_LSB +: 3] == dcs_pkg::MR_BL8;
					if (ext1)
						n.since_ext = 8'h01;
				end
				dcs_pkg::DCS_SRE: n.sref = 1'b1;
				dcs_pkg::DCS_SRX:
				begin
					n.sref = 1'b0;
					n.since_srx = 8'h01;
				end
				default:
				begin
				end
				endcase
			end
		end
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			s <= '0;
			s.since_rd <= dcs_pkg::SINCE_MAX;
			s.since_wr <= dcs_pkg::SINCE_MAX;
			s.since_ext <= dcs_pkg::SINCE_MAX;
			s.since_srx <= dcs_pkg::SINCE_MAX;
			s.since_toff <= dcs_pkg::SINCE_MAX;
		end
		else
			s <= n;
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign link.ck = s.ck;
	assign link.cmd = s.cmd;
	assign link.bank = s.bank;
	assign link.addr = s.addr;
	assign link.term = s.term;
	assign link.dq_ctl_o = s.dq_o;
	assign link.dq_ctl_oe = s.dq_oe;
	assign rd_data = s.rd_data;
	assign rd_valid = s.rd_valid;
	assign bank_open = s.open;
	assign self_refresh = s.sref;
endmodule
`default_nettype wire

// ### sim/dcs_link_sva.sv
// Link checker: command spacing and termination timing.
// Assumes plain signals taken from dcs_link_if, judged on link clock rise.
`timescale 1ns/10ps
`default_nettype none
module dcs_link_sva (
	// Link clock and reset
	input wire logic ck,
	input wire logic rst,
	// Command bus, termination and write enable
	input wire dcs_pkg::dcs_cmd_t cmd,
	input wire logic [1:0] bank,
	input wire logic [12:0] addr,
	input wire logic term,
	input wire logic dq_ctl_oe
);
	logic bl8_reg, rd_ap_reg, wr_ap_reg;
	logic [7:0] rd_age_reg, wr_age_reg, srx_age_reg, half;

	function automatic logic [7:0] age(input logic hit, input logic [7:0] v);
		return hit ? 8'h01 : ((v == dcs_pkg::SINCE_MAX) ? v : v + 8'h01);
	endfunction

	assign half = bl8_reg ? dcs_pkg::HALF_BL8 : dcs_pkg::HALF_BL4;

	// ----------------------------------------
	// Clocks since last read, write, exit
	// ----------------------------------------
	always_ff @(posedge ck or posedge rst)
	begin
		if (rst)
		begin
			bl8_reg <= 1'b0;
			rd_ap_reg <= 1'b0;
			wr_ap_reg <= 1'b0;
			rd_age_reg <= dcs_pkg::SINCE_MAX;
			wr_age_reg <= dcs_pkg::SINCE_MAX;
			srx_age_reg <= dcs_pkg::SINCE_MAX;
		end
		else
		begin
			rd_age_reg <= age(cmd == dcs_pkg::DCS_RD, rd_age_reg);
			wr_age_reg <= age(cmd == dcs_pkg::DCS_WR, wr_age_reg);
			srx_age_reg <= age(cmd == dcs_pkg::DCS_SRX, srx_age_reg);
			if (cmd == dcs_pkg::DCS_RD)
				rd_ap_reg <= addr[dcs_pkg::AUTO_PRE_BIT];
			if (cmd == dcs_pkg::DCS_WR)
				wr_ap_reg <= addr[dcs_pkg::AUTO_PRE_BIT];
			if (cmd == dcs_pkg::DCS_MODE && bank == dcs_pkg::MODE_BANK)
				bl8_reg <= (addr[2:0] == dcs_pkg::MR_BL8);
		end
	end

	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking cb @(posedge ck);
	endclocking
	default disable iff (rst);

	property p_rd_space;
		cmd == dcs_pkg::DCS_RD |-> rd_age_reg >= half
			|| (bl8_reg && !rd_ap_reg && rd_age_reg == dcs_pkg::TRUNC_GAP_CK);
	endproperty
	a_rd_space: assert property (p_rd_space)
		else $error("read to read spacing broken");
	property p_wr_space;
		cmd == dcs_pkg::DCS_WR |-> wr_age_reg >= half
			|| (bl8_reg && !wr_ap_reg && wr_age_reg == dcs_pkg::TRUNC_GAP_CK);
	endproperty
	a_wr_space: assert property (p_wr_space)
		else $error("write to write spacing broken");
	property p_rd_to_wr;
		cmd == dcs_pkg::DCS_WR |-> rd_age_reg >= (bl8_reg ? dcs_pkg::RTW_BL8_CK : dcs_pkg::RTW_BL4_CK);
	endproperty
	a_rd_to_wr: assert property (p_rd_to_wr)
		else $error("read to write too close");
	property p_wr_to_rd;
		cmd == dcs_pkg::DCS_RD |-> wr_age_reg >= dcs_pkg::COLUMN_LATENCY - 8'h01 + half + dcs_pkg::WTR_CK;
	endproperty
	a_wr_to_rd: assert property (p_wr_to_rd)
		else $error("write to read too close");
	property p_wr_to_pre;
		cmd == dcs_pkg::DCS_PRE |-> wr_age_reg >= dcs_pkg::WRITE_LATENCY + half + dcs_pkg::WR_CK;
	endproperty
	a_wr_to_pre: assert property (p_wr_to_pre)
		else $error("write to precharge too close");
	property p_wr_data;
		cmd == dcs_pkg::DCS_WR |-> ##4 dq_ctl_oe;
	endproperty
	a_wr_data: assert property (p_wr_data)
		else $error("write data not driven at write latency");
	property p_term_off;
		cmd == dcs_pkg::DCS_SRE || (cmd == dcs_pkg::DCS_MODE && bank == dcs_pkg::EXT1_BANK)
			|-> !term && !$past(term) && !$past(term, 2);
	endproperty
	a_term_off: assert property (p_term_off)
		else $error("termination on too close to command");
	property p_srx_rd;
		cmd == dcs_pkg::DCS_RD |-> srx_age_reg >= dcs_pkg::XSRD_CK;
	endproperty
	a_srx_rd: assert property (p_srx_rd)
		else $error("read too soon after refresh exit");

	c_rd_seam: cover property (cmd == dcs_pkg::DCS_RD && rd_age_reg == half);
	c_sre: cover property (cmd == dcs_pkg::DCS_SRE);
	c_srx_rd: cover property (cmd == dcs_pkg::DCS_RD && srx_age_reg < dcs_pkg::SINCE_MAX);
endmodule
`default_nettype wire

// ### sim/testbench.sv
// Bench: both link ends joined, user sides driven and judged.
// Assumes dcs_pkg, dcs_link_if, both ends and the checker compile first.
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic clk_sys, rst, req_valid, req_ready, term_enable, wr_take, rd_valid;
	dcs_pkg::dcs_cmd_t req_cmd;
	logic [1:0] req_bank, rtt;
	logic [12:0] req_addr;
	logic [31:0] wr_data, rd_data;
	logic [3:0] c_open, d_open;
	logic c_sr, d_sr, cal_on, term_on;
	logic [15:0] adj;
	logic [31:0] wbuf [8];
	logic [31:0] rbuf [8];
	int wr_idx, rd_idx, err_total, n_compared;
	bit took;

	dcs_link_if lnk ();
	dcs_controller_end u_dcs_controller_end (.clk_sys(clk_sys), .rst(rst), .link(lnk.ctl),
		.req_valid(req_valid), .req_cmd(req_cmd), .req_bank(req_bank), .req_addr(req_addr),
		.req_ready(req_ready), .term_enable(term_enable), .wr_data(wr_data), .wr_take(wr_take),
		.rd_data(rd_data), .rd_valid(rd_valid), .bank_open(c_open), .self_refresh(c_sr));
	dcs_device_end u_dcs_device_end (.link(lnk.dev), .clk_sys(clk_sys), .rst(rst),
		.bank_open(d_open), .self_refresh(d_sr), .cal_drive_active(cal_on),
		.termination_active(term_on), .rtt_nominal(rtt), .adjust_code(adj));
	dcs_link_sva u_dcs_link_sva (.ck(lnk.ck), .rst(rst), .cmd(lnk.cmd), .bank(lnk.bank),
		.addr(lnk.addr), .term(lnk.term), .dq_ctl_oe(lnk.dq_ctl_oe));

	initial
	begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end

	// ----------------------------------------
	// Write data source and read capture
	// ----------------------------------------
	always @(negedge clk_sys)
		wr_data <= wbuf[wr_idx];
	always @(posedge clk_sys)
	begin
		if (wr_take === 1'b1)
			wr_idx <= wr_idx + 1;
		if (rd_valid === 1'b1)
		begin
			rbuf[rd_idx] <= rd_data;
			rd_idx <= rd_idx + 1;
		end
	end

	task automatic complete_run();
		if (err_total == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			err_total++;
			$display("Error at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic issue(input dcs_pkg::dcs_cmd_t c, input logic [1:0] b,
		input logic [12:0] a, input int lim);
		took = 1'b0;
		@(negedge clk_sys);
		req_valid = 1'b1;
		req_cmd = c;
		req_bank = b;
		req_addr = a;
		for (int i = 0; i < lim && !took; i++)
		begin
			#1;
			took = (req_ready === 1'b1);
			@(negedge clk_sys);
		end
		req_valid = 1'b0;
	endtask
	task automatic send(input dcs_pkg::dcs_cmd_t c, input logic [1:0] b, input logic [12:0] a);
		issue(c, b, a, 1000);
		if (!took)
		begin
			err_total++;
			complete_run();
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(negedge clk_sys);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_rtt();
		term_enable = 1'b1;
		send(dcs_pkg::DCS_MODE, dcs_pkg::EXT1_BANK, 13'h0044);
		idle(12);
		chk(32'(rtt), 32'h00000003);
		send(dcs_pkg::DCS_MODE, dcs_pkg::EXT1_BANK, 13'h0040);
		idle(12);
		chk(32'(rtt), 32'h00000002);
		send(dcs_pkg::DCS_MODE, dcs_pkg::EXT1_BANK, 13'h0004);
		idle(40);
		chk(32'(rtt), 32'h00000001);
		chk(32'(term_on), 32'h00000001);
	endtask
	task automatic t_drive();
		send(dcs_pkg::DCS_MODE, dcs_pkg::EXT1_BANK, {3'h0, dcs_pkg::CAL_DRIVE1, 7'h04});
		idle(12);
		chk(32'(cal_on), 32'h00000001);
		chk(lnk.dq, 32'hFFFFFFFF);
		send(dcs_pkg::DCS_MODE, dcs_pkg::EXT1_BANK, {3'h0, dcs_pkg::CAL_EXIT, 7'h04});
		idle(12);
		chk(32'({cal_on, lnk.dq_dev_oe}), 32'h00000000);
	endtask
	task automatic t_adjust();
		for (int i = 0; i < 4; i++)
			wbuf[i] = 32'h000000A1 + i;
		wr_idx = 0;
		send(dcs_pkg::DCS_MODE, dcs_pkg::MODE_BANK, 13'h000B);
		send(dcs_pkg::DCS_MODE, dcs_pkg::EXT1_BANK, {3'h0, dcs_pkg::CAL_ADJUST, 7'h04});
		send(dcs_pkg::DCS_ACT, 2'h2, 13'h0000);
		send(dcs_pkg::DCS_WR, 2'h2, 13'h0001);
		idle(30);
		chk(32'(adj), 32'h00004321);
		send(dcs_pkg::DCS_PRE, 2'h0, 13'h0400);
		send(dcs_pkg::DCS_MODE, dcs_pkg::EXT1_BANK, {3'h0, dcs_pkg::CAL_EXIT, 7'h04});
	endtask
	task automatic t_wr_rd();
		for (int i = 0; i < 4; i++)
			wbuf[i] = 32'h12345670 + i;
		wr_idx = 0;
		rd_idx = 0;
		send(dcs_pkg::DCS_MODE, dcs_pkg::MODE_BANK, 13'h0002);
		send(dcs_pkg::DCS_ACT, 2'h1, 13'h0000);
		send(dcs_pkg::DCS_WR, 2'h1, 13'h0004);
		send(dcs_pkg::DCS_WR, 2'h1, 13'h0006);
		send(dcs_pkg::DCS_RD, 2'h1, 13'h0004);
		send(dcs_pkg::DCS_RD, 2'h1, 13'h0006);
		for (int i = 0; i < 400 && rd_idx < 4; i++)
			@(negedge clk_sys);
		for (int i = 0; i < 4; i++)
			chk(rbuf[i], wbuf[i]);
		chk(32'({c_open, d_open}), 32'h00000022);
	endtask
	task automatic t_trunc();
		for (int i = 0; i < 4; i++)
			wbuf[i] = 32'hC0DE0000 + i;
		wr_idx = 0;
		rd_idx = 0;
		send(dcs_pkg::DCS_PRE, 2'h0, 13'h0400);
		send(dcs_pkg::DCS_MODE, dcs_pkg::MODE_BANK, 13'h0003);
		send(dcs_pkg::DCS_ACT, 2'h3, 13'h0000);
		send(dcs_pkg::DCS_WR, 2'h3, 13'h0000);
		send(dcs_pkg::DCS_RD, 2'h3, 13'h0000);
		// Second read cuts the first short after two words
		send(dcs_pkg::DCS_RD, 2'h3, 13'h0000);
		for (int i = 0; i < 400 && rd_idx < 6; i++)
			@(negedge clk_sys);
		chk(rbuf[0], wbuf[0]);
		chk(rbuf[1], wbuf[1]);
		for (int i = 0; i < 4; i++)
			chk(rbuf[i + 2], wbuf[i]);
	endtask
	task automatic t_sr();
		issue(dcs_pkg::DCS_SRE, 2'h0, 13'h0000, 60);
		chk(32'(took), 32'h00000000);
		send(dcs_pkg::DCS_PRE, 2'h0, 13'h0400);
		send(dcs_pkg::DCS_SRE, 2'h0, 13'h0000);
		idle(12);
		chk(32'({c_sr, d_sr}), 32'h00000003);
		send(dcs_pkg::DCS_SRX, 2'h0, 13'h0000);
		send(dcs_pkg::DCS_ACT, 2'h1, 13'h0000);
		send(dcs_pkg::DCS_RD, 2'h1, 13'h0004);
		send(dcs_pkg::DCS_WR, 2'h1, 13'h0004);
		idle(12);
		chk(32'({c_sr, d_sr}), 32'h00000000);
	endtask

	initial
	begin
		rst = 1'b1;
		req_valid = 1'b0;
		req_cmd = dcs_pkg::DCS_NOP;
		req_bank = 2'h0;
		req_addr = 13'h0000;
		term_enable = 1'b0;
		wr_idx = 0;
		rd_idx = 0;
		err_total = 0;
		n_compared = 0;
		repeat (2) @(posedge clk_sys);
		@(negedge clk_sys);
		rst = 1'b0;
		chk(32'({c_open, d_open, c_sr, d_sr}), 32'h00000000);
		t_rtt();
		t_drive();
		t_adjust();
		t_wr_rd();
		t_trunc();
		t_sr();
		complete_run();
	end
	initial
	begin
		#3000000;
		err_total++;
		complete_run();
	end
endmodule
`default_nettype wire
